// file: pcp_pkg.sv
// constants shared by the pack configuration policy block
`default_nettype none
package pcp_pkg;
    // ****************
    // clock and timing
    // ****************
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned HOLD_TIME_MS    = 1000;
    localparam int unsigned HOLD_CYCLES     = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned TAPER_WINDOWS   = 2;

    // ****************
    // register offsets
    // ****************
    localparam logic [7:0] OFS_OPTIONS_A = 8'h00;
    localparam logic [7:0] OFS_OPTIONS_B = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] OFS_LIVE      = 8'h10;

    // ****************
    // reset values
    // ****************
    localparam logic [15:0] RST_OPTIONS_A = 16'h0f29;
    localparam logic [15:0] RST_OPTIONS_B = 16'h6440;
    localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;

    // ****************
    // option word a fields
    // ****************
    localparam int unsigned A_LED_BASIS   = 12;
    localparam int unsigned A_SERIES_LED  = 2;
    localparam int unsigned A_PRECHG_HI   = 1;
    localparam int unsigned A_PRECHG_LO   = 0;

    // ****************
    // option word b fields
    // ****************
    localparam int unsigned B_FAIL_HI     = 15;
    localparam int unsigned B_FAIL_LO     = 14;
    localparam int unsigned B_RESERVE     = 13;
    localparam int unsigned B_BUS_EXT     = 12;
    localparam int unsigned B_SLEEP_KEEP  = 11;
    localparam int unsigned B_CAP_SYNC    = 10;
    localparam int unsigned B_TERM_CLR    = 9;
    localparam int unsigned B_CYCLE_METH  = 8;
    localparam int unsigned B_SUSP_FET    = 7;
    localparam int unsigned B_OTEMP_FET   = 6;
    localparam int unsigned B_ALARM_FET   = 5;
    localparam int unsigned B_INHIB_FET   = 4;
    localparam int unsigned B_FIXED_PACK  = 3;

    // ****************
    // encodings
    // ****************
    localparam logic [1:0] PRE_NONE   = 2'h3;
    localparam logic [1:0] PRE_OD     = 2'h2;
    localparam logic [1:0] PRE_ALARM_FET_OPEN = 2'h1;
    localparam logic [1:0] PRE_ZVFET  = 2'h0;
    localparam logic [1:0] FAIL_ANY   = 2'h3;
    localparam logic [1:0] FAIL_HOLD  = 2'h1;

    // interrupt status bits
    localparam int unsigned IRQ_TERM_CLR = 0;
    localparam int unsigned IRQ_CAP_LOAD = 1;
    localparam int unsigned IRQ_CHG_OFF  = 2;
    localparam int unsigned IRQ_PF_SHOW  = 3;
    localparam int unsigned IRQ_BITS     = 4;

    typedef enum logic [1:0] {
        PCP_LED_SHOW_BUTTON_IDLE = 2'b00,
        PCP_LED_SHOW_BUTTON_SOC  = 2'b01,
        PCP_LED_SHOW_BUTTON_FAIL = 2'b11
    } pcp_led_show_button_e;
endpackage
`default_nettype wire

// file: pcp_sync2.sv
// two flip-flop synchroniser for asynchronous pins
`default_nettype none
module pcp_sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } pcp_sync_s;

    pcp_sync_s sync_reg;
    pcp_sync_s sync_next;

    initial begin
        if (WIDTH < 1) $error("width must be at least one");
    end

    always_comb begin
        sync_next      = sync_reg;
        sync_next.meta = async_in;
        sync_next.held = sync_reg.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_reg <= '{meta: INIT, held: INIT};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.held;
endmodule // pcp_sync2
`default_nettype wire

// file: pcp_press_timer.sv
// button press edge and long press detection
`default_nettype none
module pcp_press_timer #(
    parameter int unsigned HOLD_CYCLES = 10_000_000
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pressed,
    output var  logic press_start,
    output var  logic held_long
);
    localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

    typedef struct packed {
        logic          was_pressed;
        logic [CW-1:0] count;
        logic          start;
        logic          long_hold;
    } pcp_press_s;

    pcp_press_s pt_reg;
    pcp_press_s pt_next;

    initial begin
        if (HOLD_CYCLES < 1) $error("hold count must be at least one");
    end

    always_comb begin
        pt_next             = pt_reg;
        pt_next.was_pressed = pressed;
        pt_next.start       = pressed && !pt_reg.was_pressed;
        if (!pressed) begin
            pt_next.count     = '0;
            pt_next.long_hold = 1'b0;
        end else if (pt_reg.count != CW'(HOLD_CYCLES)) begin
            pt_next.count = pt_reg.count + CW'(1);
        end else begin
            pt_next.long_hold = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pt_reg <= '0;
        end else begin
            pt_reg <= pt_next;
        end
    end

    assign press_start = pt_reg.start;
    assign held_long   = pt_reg.long_hold;
endmodule // pcp_press_timer
`default_nettype wire

// file: pcp_policy.sv
// configuration driven charge, fet and led policy with ahb-lite registers
`default_nettype none
// Functional notes
// - series led: 0 parallel, 1 serial, which blocks fail display
// - precharge path: 11 none, 10 open drain, 01 chg fet, 00 zv fet
// - fail display: 11 any press, 01 long press, else off
// - no permanent failure, no fail display
// - reserve comp: 0 no-load, 1 load-select
// - bus timeout: 0 normal, 1 unlimited
// - fixed pack: sleep keep 0 opens, 1 keeps charge fet
// - capacity sync loads remaining from full capacity on termination
// - term clear clears alarm and full flags after two taper windows
// - cycle method: 0 mAh threshold, 1 percent of full capacity
// - suspend bit opens charge and precharge fets in suspension
// - overtemp bit opens the faulted direction's fet
// - alarm bit: charge fet off while alarm flag set
// - inhibit bit: charge fet off in charge inhibit
// - defaults: fail display 01, parallel led drive
// - soc basis: 0 relative, 1 absolute percent
// - fixed pack: 0 removable, 1 non-removable
module pcp_policy #(
    parameter int unsigned HOLD_CYCLES = pcp_pkg::HOLD_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic [31:0] hrdata,
    output var  logic        hresp,
    input  wire logic        led_show_button_n,
    input  wire logic        fail_present,
    input  wire logic        soc_show_done,
    input  wire logic        fail_show_done,
    input  wire logic        charge_enable,
    input  wire logic        discharge_enable,
    input  wire logic        precharge_request,
    input  wire logic        sleep_active,
    input  wire logic        charge_suspend,
    input  wire logic        charge_inhibit,
    input  wire logic        overtemp_chg,
    input  wire logic        overtemp_dsg,
    input  wire logic        terminate_charge_alarm,
    input  wire logic        primary_term,
    input  wire logic        taper_window_end,
    input  wire logic        below_taper,
    output var  logic        chg_fet_on,
    output var  logic        dsg_fet_on,
    output var  logic        zvchg_fet_on,
    output var  logic        open_drain_output,
    output var  logic        soc_display_active,
    output var  logic        fail_display_active,
    output var  logic        series_led_select,
    output var  logic        led_basis_select,
    output var  logic        reserve_load_comp,
    output var  logic        bus_timeout_extend,
    output var  logic        fixed_pack_mode,
    output var  logic        cycle_method_select,
    output var  logic        capacity_load,
    output var  logic        term_flags_clear,
    output var  logic        irq
);
    // ****************
    // state
    // ****************
    typedef struct packed {
        logic [15:0]                    opt_a;
        logic [15:0]                    opt_b;
        logic [pcp_pkg::IRQ_BITS-1:0]   irq_stat;
        logic [pcp_pkg::IRQ_BITS-1:0]   irq_mask;
        pcp_pkg::pcp_led_show_button_e             led_show_button;
        logic                           long_seen;
        logic                           term_pending;
        logic [1:0]                     taper_cnt;
        logic                           ph_valid;
        logic                           ph_write;
        logic [7:0]                     ph_addr;
        logic [31:0]                    rdata;
        logic                           chg_on;
        logic                           dsg_on;
        logic                           zv_on;
        logic                           od_on;
        logic                           cap_load;
        logic                           term_clr;
        logic                           irq_out;
    } pcp_policy_s;

    pcp_policy_s st_reg;
    pcp_policy_s st_next;

    logic button_sync_n;
    logic press_start;
    logic held_long;

    initial begin
        if (HOLD_CYCLES < 1) $error("hold count must be at least one");
    end

    // ****************
    // button input
    // ****************
    pcp_sync2 #(
        .WIDTH (1),
        .INIT  (1'b1)
    ) u_button_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (led_show_button_n),
        .sync_out (button_sync_n)
    );

    pcp_press_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_press_timer (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .pressed     (!button_sync_n),
        .press_start (press_start),
        .held_long   (held_long)
    );

    // ****************
    // next state
    // ****************
    always_comb begin
        logic       accept;
        logic       rd_stat;
        logic       serial;
        logic [1:0] fail_sel;
        logic [1:0] pre_sel;
        logic       fail_ok;
        logic       chg_block;
        logic       pre_block;
        logic       pre_req;
        logic       term_clr_ev;
        logic       cap_ev;
        logic [pcp_pkg::IRQ_BITS-1:0] ev;

        accept      = 1'b0;
        rd_stat     = 1'b0;
        serial      = 1'b0;
        fail_sel    = 2'h0;
        pre_sel     = 2'h0;
        fail_ok     = 1'b0;
        chg_block   = 1'b0;
        pre_block   = 1'b0;
        pre_req     = 1'b0;
        term_clr_ev = 1'b0;
        cap_ev      = 1'b0;
        ev          = '0;
        st_next     = st_reg;

        // bus data phase: writes land here
        if (st_reg.ph_valid && st_reg.ph_write) begin
            case (st_reg.ph_addr)
                pcp_pkg::OFS_OPTIONS_A: st_next.opt_a = hwdata[15:0];
                pcp_pkg::OFS_OPTIONS_B: st_next.opt_b = hwdata[15:0];
                pcp_pkg::OFS_IRQ_MASK: begin
                    st_next.irq_mask = hwdata[pcp_pkg::IRQ_BITS-1:0];
                end
                default: ;
            endcase
        end

        // bus address phase: whole-word writes, reads of any size, zero wait
        accept = hsel && hready && htrans[1];
        st_next.ph_valid = accept && (hsize == 3'h2);
        st_next.ph_write = hwrite;
        st_next.ph_addr  = haddr[7:0];
        st_next.rdata    = 32'h0;
        if (accept && !hwrite && (haddr[31:8] == 24'h0)) begin
            case (haddr[7:0])
                pcp_pkg::OFS_OPTIONS_A: st_next.rdata = {16'h0, st_reg.opt_a};
                pcp_pkg::OFS_OPTIONS_B: st_next.rdata = {16'h0, st_reg.opt_b};
                pcp_pkg::OFS_IRQ_STAT: begin
                    st_next.rdata = {28'h0, st_reg.irq_stat};
                    rd_stat       = 1'b1;
                end
                pcp_pkg::OFS_IRQ_MASK: begin
                    st_next.rdata = {28'h0, st_reg.irq_mask};
                end
                pcp_pkg::OFS_LIVE: begin
                    st_next.rdata = {22'h0, st_reg.term_pending,
                                     st_reg.taper_cnt, st_reg.led_show_button,
                                     st_reg.od_on, st_reg.zv_on,
                                     st_reg.dsg_on, st_reg.chg_on,
                                     st_reg.long_seen};
                end
                default: st_next.rdata = 32'h0;
            endcase
        end

        // option decode
        serial   = st_reg.opt_a[pcp_pkg::A_SERIES_LED];
        pre_sel  = st_reg.opt_a[pcp_pkg::A_PRECHG_HI:pcp_pkg::A_PRECHG_LO];
        fail_sel = st_reg.opt_b[pcp_pkg::B_FAIL_HI:pcp_pkg::B_FAIL_LO];

        // led display sequence: soc first, fail data after
        if (press_start) begin
            st_next.long_seen = 1'b0;
        end else if (held_long) begin
            st_next.long_seen = 1'b1;
        end
        fail_ok = !serial && fail_present
                  && ((fail_sel == pcp_pkg::FAIL_ANY)
                  || ((fail_sel == pcp_pkg::FAIL_HOLD)
                      && (st_reg.long_seen || held_long)));
        case (st_reg.led_show_button)
            pcp_pkg::PCP_LED_SHOW_BUTTON_IDLE: begin
                if (press_start) st_next.led_show_button = pcp_pkg::PCP_LED_SHOW_BUTTON_SOC;
            end
            pcp_pkg::PCP_LED_SHOW_BUTTON_SOC: begin
                if (soc_show_done) begin
                    if (fail_ok) begin
                        st_next.led_show_button = pcp_pkg::PCP_LED_SHOW_BUTTON_FAIL;
                        ev[pcp_pkg::IRQ_PF_SHOW] = 1'b1;
                    end else begin
                        st_next.led_show_button = pcp_pkg::PCP_LED_SHOW_BUTTON_IDLE;
                    end
                end
            end
            pcp_pkg::PCP_LED_SHOW_BUTTON_FAIL: begin
                if (fail_show_done || serial || !fail_present) begin
                    st_next.led_show_button = pcp_pkg::PCP_LED_SHOW_BUTTON_IDLE;
                end
            end
            default: st_next.led_show_button = pcp_pkg::PCP_LED_SHOW_BUTTON_IDLE;
        endcase

        // primary termination and taper windows
        cap_ev = primary_term
                 && st_reg.opt_b[pcp_pkg::B_CAP_SYNC];
        if (primary_term) begin
            st_next.term_pending = 1'b1;
            st_next.taper_cnt    = 2'h0;
        end else if (st_reg.term_pending && taper_window_end) begin
            if (!below_taper) begin
                st_next.taper_cnt = 2'h0;
            end else if (st_reg.taper_cnt == 2'(pcp_pkg::TAPER_WINDOWS - 1)) begin
                st_next.taper_cnt    = 2'h0;
                st_next.term_pending = 1'b0;
                term_clr_ev = st_reg.opt_b[pcp_pkg::B_TERM_CLR];
            end else begin
                st_next.taper_cnt = st_reg.taper_cnt + 2'h1;
            end
        end
        st_next.cap_load = cap_ev;
        st_next.term_clr = term_clr_ev;
        ev[pcp_pkg::IRQ_CAP_LOAD] = cap_ev;
        ev[pcp_pkg::IRQ_TERM_CLR] = term_clr_ev;

        // fet policy
        pre_block = charge_suspend
                    && st_reg.opt_b[pcp_pkg::B_SUSP_FET];
        chg_block = pre_block
                    || (overtemp_chg
                        && st_reg.opt_b[pcp_pkg::B_OTEMP_FET])
                    || (terminate_charge_alarm
                        && st_reg.opt_b[pcp_pkg::B_ALARM_FET])
                    || (charge_inhibit
                        && st_reg.opt_b[pcp_pkg::B_INHIB_FET])
                    || (sleep_active
                        && st_reg.opt_b[pcp_pkg::B_FIXED_PACK]
                        && !st_reg.opt_b[pcp_pkg::B_SLEEP_KEEP]);
        pre_req = precharge_request && !pre_block;
        st_next.chg_on = !chg_block && (charge_enable
                         || (pre_req && (pre_sel == pcp_pkg::PRE_ALARM_FET_OPEN)));
        st_next.zv_on  = pre_req && (pre_sel == pcp_pkg::PRE_ZVFET);
        st_next.od_on  = pre_req && (pre_sel == pcp_pkg::PRE_OD);
        st_next.dsg_on = discharge_enable && !(overtemp_dsg
                         && st_reg.opt_b[pcp_pkg::B_OTEMP_FET]);
        ev[pcp_pkg::IRQ_CHG_OFF] = st_reg.chg_on && !st_next.chg_on;

        // sticky status, read clears, a new event wins over the clear
        st_next.irq_stat = (rd_stat ? '0 : st_reg.irq_stat) | ev;
        st_next.irq_out  = |(st_next.irq_stat & st_next.irq_mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg          <= '0;
            st_reg.opt_a    <= pcp_pkg::RST_OPTIONS_A;
            st_reg.opt_b    <= pcp_pkg::RST_OPTIONS_B;
            st_reg.irq_mask <= pcp_pkg::RST_IRQ_MASK;
            st_reg.led_show_button     <= pcp_pkg::PCP_LED_SHOW_BUTTON_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************
    // outputs
    // ****************
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign hrdata              = st_reg.rdata;
    assign chg_fet_on          = st_reg.chg_on;
    assign dsg_fet_on          = st_reg.dsg_on;
    assign zvchg_fet_on        = st_reg.zv_on;
    assign open_drain_output   = st_reg.od_on;
    assign soc_display_active  = (st_reg.led_show_button == pcp_pkg::PCP_LED_SHOW_BUTTON_SOC);
    assign fail_display_active = (st_reg.led_show_button == pcp_pkg::PCP_LED_SHOW_BUTTON_FAIL);
    assign series_led_select   = st_reg.opt_a[pcp_pkg::A_SERIES_LED];
    assign led_basis_select    = st_reg.opt_a[pcp_pkg::A_LED_BASIS];
    assign reserve_load_comp   = st_reg.opt_b[pcp_pkg::B_RESERVE];
    assign bus_timeout_extend  = st_reg.opt_b[pcp_pkg::B_BUS_EXT];
    assign fixed_pack_mode     = st_reg.opt_b[pcp_pkg::B_FIXED_PACK];
    assign cycle_method_select = st_reg.opt_b[pcp_pkg::B_CYCLE_METH];
    assign capacity_load       = st_reg.cap_load;
    assign term_flags_clear    = st_reg.term_clr;
    assign irq                 = st_reg.irq_out;
endmodule // pcp_policy
`default_nettype wire

// file: pcp_afe_model.sv
// behavioural analog front end that follows the fet commands
`default_nettype none
module pcp_afe_model (
    input  wire logic hclk,
    input  wire logic chg_fet_on,
    input  wire logic dsg_fet_on,
    input  wire logic zvchg_fet_on,
    input  wire logic open_drain_output,
    output var  logic chg_path,
    output var  logic dsg_path
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // fet gate drive
    // ****************
    always @(posedge hclk) begin
        chg_path <= chg_fet_on | zvchg_fet_on | open_drain_output;
        dsg_path <= dsg_fet_on;
    end
endmodule // pcp_afe_model
`default_nettype wire

// file: pcp_policy_props.sv
// port assertions for the pack configuration policy block
`default_nettype none
module pcp_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        fail_present,
    input wire logic        discharge_enable,
    input wire logic        precharge_request,
    input wire logic        primary_term,
    input wire logic        taper_window_end,
    input wire logic        below_taper,
    input wire logic        zvchg_fet_on,
    input wire logic        open_drain_output,
    input wire logic        dsg_fet_on,
    input wire logic        soc_display_active,
    input wire logic        fail_display_active,
    input wire logic        series_led_select,
    input wire logic        capacity_load,
    input wire logic        term_flags_clear
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence no_wr;
        !(hsel && hready && htrans[1] && hwrite);
    endsequence
    sequence no_rd;
        !(hsel && hready && htrans[1] && !hwrite);
    endsequence
    bus_ready_a: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    rd_idle_a: assert property (no_rd |=> hrdata == 32'h0)
        else $error("stray read data");
    opt_hold_a: assert property (
        no_wr ##2 1 |-> $stable(series_led_select))
        else $error("option moved");
    fail_cause_a: assert property (
        $rose(fail_display_active) |-> $past(fail_present))
        else $error("no failure");
    serial_block_a: assert property (
        $rose(fail_display_active) |-> !$past(series_led_select))
        else $error("serial fail shown");
    fail_order_a: assert property (
        $rose(fail_display_active) |-> $past(soc_display_active))
        else $error("fail not after soc");
    cap_pulse_a: assert property (
        capacity_load |-> $past(primary_term))
        else $error("stray capacity load");
    term_pulse_a: assert property (
        term_flags_clear |-> $past(taper_window_end && below_taper))
        else $error("stray flag clear");
    pre_path_a: assert property (
        (zvchg_fet_on || open_drain_output) |-> $past(precharge_request)
        && !(zvchg_fet_on && open_drain_output))
        else $error("precharge path wrong");
    dsg_cause_a: assert property (
        dsg_fet_on |-> $past(discharge_enable))
        else $error("stray discharge fet");
endmodule // pcp_chk
bind pcp_policy pcp_chk pcp_chk_i (.*);
`default_nettype wire

// file: testbench.sv
// self-checking testbench for the pack configuration policy block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // signals and model state
    // ****************
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        btn_n, fpres, btaper, chg, dsg, zv, od, socd, faild;
    logic        ser, basis, resv, busx, fixp, cycm, capl, tclr;
    logic [3:0]  pls, ef;
    logic [8:0]  fin;
    logic [15:0] rnd, oa, ob;
    int          n_errors, num_checks, cyc, n_cap, n_term;
    logic [1:0]  sl [7] = '{3, 1, 1, 2, 0, 3, 3};
    logic        sr [7] = '{0, 0, 0, 0, 0, 1, 0};
    logic        pf [7] = '{1, 1, 1, 1, 1, 1, 0};
    logic        lg [7] = '{0, 0, 1, 1, 1, 0, 0};
    logic        fx [7] = '{1, 0, 1, 0, 0, 0, 0};

    pcp_policy #(.HOLD_CYCLES(20)) pcp_policy_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .led_show_button_n(btn_n),
        .fail_present(fpres), .soc_show_done(pls[1]),
        .fail_show_done(pls[2]), .charge_enable(fin[8]),
        .discharge_enable(fin[7]), .precharge_request(fin[6]),
        .sleep_active(fin[5]), .charge_suspend(fin[4]),
        .charge_inhibit(fin[3]), .overtemp_chg(fin[2]),
        .overtemp_dsg(fin[1]), .terminate_charge_alarm(fin[0]),
        .primary_term(pls[0]), .taper_window_end(pls[3]),
        .below_taper(btaper), .chg_fet_on(chg), .dsg_fet_on(dsg),
        .zvchg_fet_on(zv), .open_drain_output(od),
        .soc_display_active(socd), .fail_display_active(faild),
        .series_led_select(ser), .led_basis_select(basis),
        .reserve_load_comp(resv), .bus_timeout_extend(busx),
        .fixed_pack_mode(fixp), .cycle_method_select(cycm),
        .capacity_load(capl), .term_flags_clear(tclr), .irq);
    pcp_afe_model pcp_afe_model_i (.hclk, .chg_fet_on(chg),
        .dsg_fet_on(dsg), .zvchg_fet_on(zv), .open_drain_output(od),
        .chg_path(), .dsg_path());

    // ****************
    // tasks and model
    // ****************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] fet_exp(input logic [15:0] a, b,
        input logic [8:0] f);
        logic off;
        logic sus;
        sus = b[7] & f[4];
        off = sus | (b[6] & f[2]) | (b[5] & f[0]) | (b[4] & f[3])
            | (b[3] & ~b[11] & f[5]);
        return {(f[8] | (f[6] & (a[1:0] == 2'h1))) & ~off,
                f[7] & ~(b[6] & f[1]), f[6] & (a[1:0] == 2'h0) & ~sus,
                f[6] & (a[1:0] == 2'h2) & ~sus};
    endfunction
    task automatic check(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic pulse(input int b);
        @(posedge hclk);
        pls[b] <= 1'b1;
        @(posedge hclk);
        pls[b] <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************
    // clock, timeout and pulse counters
    // ****************
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        n_cap += int'(capl);
        n_term += int'(tclr);
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // ****************
    // test sequence
    // ****************
    initial begin
        {hresetn, hsel, hwrite, btaper, fpres, pls, fin} = '0;
        {haddr, hwdata, htrans, hsize, btn_n} = {66'h0, 3'h2, 1'b1};
        {rnd, n_errors, num_checks, cyc, n_cap, n_term} = {16'hd5ec, 160'h0};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, rdv);
        check(rdv[15:14], 2'h1);
        check(rdv, {16'h0, pcp_pkg::RST_OPTIONS_B});
        check(ser, 1'b0);
        wr(8'h00, 32'hffff_1004);
        wr(8'h20, 32'hffff_ffff);
        bus(1'b0, 8'h20, 32'h0, rdv);
        check(rdv, 32'h0);
        bus(1'b0, 8'h00, 32'h0, rdv);
        check(rdv, 32'h1004);
        $display("test registers done");
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            oa = {rnd[15:2], i[1:0]};
            rnd = lfsr(rnd);
            ob = rnd;
            wr(8'h00, {16'h0, oa});
            wr(8'h04, {16'h0, ob});
            rnd = lfsr(rnd);
            fin <= rnd[8:0];
            repeat (3) @(posedge hclk);
            ef = fet_exp(oa, ob, fin);
            check(chg, ef[3]);
            check({dsg, zv, od}, ef[2:0]);
            check({ser, basis}, {oa[2], oa[12]});
            check({resv, busx}, ob[13:12]);
            check({fixp, cycm}, {ob[3], ob[8]});
        end
        $display("test fet policy done");
        fin <= '0;
        wr(8'h04, 32'h0400);
        wr(8'h0c, 32'h2);
        bus(1'b0, 8'h08, 32'h0, rdv);
        pulse(0);
        check(n_cap, 1);
        check(irq, 1'b1);
        bus(1'b0, 8'h08, 32'h0, rdv);
        check(rdv, 32'h2);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        wr(8'h04, 32'h0200);
        pulse(0);
        for (int j = 0; j < 4; j++) begin
            btaper <= (j != 1);
            pulse(3);
            check(n_term, int'(j == 3));
        end
        check({n_cap[3:0], irq}, 5'h2);
        bus(1'b0, 8'h08, 32'h0, rdv);
        check(rdv, 32'h1);
        $display("test events done");
        for (int i = 0; i < 7; i++) begin
            wr(8'h00, {29'h0, sr[i], 2'h1});
            wr(8'h04, {16'h0, sl[i], 14'h0});
            fpres <= pf[i];
            btn_n <= 1'b0;
            repeat (lg[i] ? 40 : 3) @(posedge hclk);
            btn_n <= 1'b1;
            for (int k = 0; k < 20 && socd !== 1'b1; k++) @(posedge hclk);
            check(socd, 1'b1);
            pulse(1);
            check(faild, fx[i]);
            pulse(2);
            check(faild, 1'b0);
        end
        $display("test display done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
